// [inc/rscr_pkg.sv]
// Package: register map, field layout and carriers of the config bank
package rscr_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_POINTS   = 8'h0C;
	localparam logic [7:0] IDX_XFER     = 8'h0E;
	localparam logic [7:0] IDX_TRIG     = 8'h0F;
	localparam logic [7:0] IDX_FREQ     = 8'h10;
	localparam logic [7:0] IDX_LEVEL    = 8'h11;
	localparam logic [7:0] IDX_ENABLE   = 8'h12;
	localparam logic [7:0] IDX_PHASE    = 8'h13;
	localparam logic [7:0] IDX_AUTOLVL  = 8'h14;
	localparam logic [7:0] IDX_LOOP     = 8'h15;
	localparam logic [7:0] IDX_STANDBY  = 8'h16;
	localparam logic [7:0] IDX_REFCTL   = 8'h17;
	localparam logic [7:0] IDX_TRIM     = 8'h18;
	localparam logic [7:0] IDX_ATTEN    = 8'h1A;
	localparam logic [7:0] IDX_UPPER    = 8'h20;
	localparam logic [7:0] IDX_STATUS   = 8'h21;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int BIT_CTL0       = 0;
	localparam int BIT_REFOUT     = 1;
	localparam int BIT_LVL_SIGN   = 15;
	localparam int LVL_MAG_W      = 15;
	localparam int PHASE_W        = 31;
	localparam int TRIM_W         = 14;
	localparam int ATT_W          = 8;
	localparam int BIT_ATT_BANK   = 8;
	localparam int POINTS_W       = 16;
	localparam int UPPER_W        = 24;
	localparam logic [7:0] LF_ATT_MAX = 8'h20;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [55:0] RST_FREQ   = 56'h0;
	localparam logic [15:0] RST_POINTS = 16'h0000;
	localparam logic [13:0] RST_TRIM   = 14'h0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [55:0] freq_mhz;
		logic        level_neg;
		logic [14:0] level_mag;
		logic [30:0] phase;
		logic        out_on;
		logic        standby;
		logic        auto_lvl_off;
		logic        loop_open;
	} rscr_chan_t;

	typedef struct packed {
		logic        override;
		logic        lf_bank;
		logic [7:0]  hf_code;
		logic [7:0]  lf_code;
	} rscr_atten_t;

	typedef struct packed {
		logic        req;
		logic        to_buffer;
		logic [15:0] points;
	} rscr_xfer_t;

endpackage

// [test/rf_source_config_registers_bench.sv]
// Testbench of the configuration bank with a host model on the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
	num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
	end end
module rf_source_config_registers_bench;
	logic                  core_clk;
	logic                  srst = 1'b1;
	logic                  ext_ref_present = 1'b0;
	logic                  hsel, hwrite, hreadyout, hresp;
	logic [7:0]            haddr;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic [31:0]           hwdata, hrdata;
	logic                  soft_trigger, relevel_req, ext_lock_try, ref_out_100m;
	logic [13:0]           osc_trim;
	rscr_pkg::rscr_chan_t  chan_cfg;
	rscr_pkg::rscr_atten_t atten_cfg;
	rscr_pkg::rscr_xfer_t  xfer_cmd;
	int                    num_errors = 0, n_tests = 0, cyc = 0;
	int                    n_trig = 0, n_lvl = 0, n_req = 0;

	rscr_config_bank u_dut (.core_clk(core_clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ext_ref_present(ext_ref_present),
		.chan_cfg(chan_cfg), .atten_cfg(atten_cfg), .xfer_cmd(xfer_cmd),
		.soft_trigger(soft_trigger), .relevel_req(relevel_req),
		.ext_lock_try(ext_lock_try), .ref_out_100m(ref_out_100m),
		.osc_trim(osc_trim));
	rscr_host_model u_host (.core_clk(core_clk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Clock and a cycle ceiling well above the ~100 cycles needed
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		n_trig <= n_trig + (soft_trigger === 1'b1);
		n_lvl <= n_lvl + (relevel_req === 1'b1);
		n_req <= n_req + (xfer_cmd.req === 1'b1);
		if (cyc == 4000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Frequency, level and leveling control; pulses counted per edge
	task automatic t_freq();
		int l0;
		l0 = n_lvl;
		`CHK("freq0", rscr_pkg::RST_FREQ, chan_cfg.freq_mhz)
		u_host.wr56(rscr_pkg::IDX_FREQ, 56'hABCDEF12345678);
		#1;
		`CHK("freq", 56'hABCDEF12345678, chan_cfg.freq_mhz)
		u_host.wr(rscr_pkg::IDX_AUTOLVL, 32'h1);
		#1;
		`CHK("autolvl", 1'b1, chan_cfg.auto_lvl_off)
		u_host.wr56(rscr_pkg::IDX_FREQ, 56'h00000100000001);
		u_host.wr(rscr_pkg::IDX_LEVEL, 32'h8401);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("relevel", l0 + 2, n_lvl)
		`CHK("lvl_neg", 1'b1, chan_cfg.level_neg)
		`CHK("lvl_mag", 15'h0401, chan_cfg.level_mag)
		u_host.wr(rscr_pkg::IDX_PHASE, 32'h7FFFFFFF);
		u_host.wr(rscr_pkg::IDX_TRIM, 32'h3FFF);
		#1;
		`CHK("phase", 31'h7FFFFFFF, chan_cfg.phase)
		`CHK("trim", 14'h3FFF, osc_trim)
	endtask

	// Single-bit controls, set then cleared; unused bits sent as zero
	task automatic t_bits();
		for (int v = 1; v >= 0; v--) begin
			u_host.wr(rscr_pkg::IDX_ENABLE, 32'(v));
			u_host.wr(rscr_pkg::IDX_STANDBY, 32'(v));
			u_host.wr(rscr_pkg::IDX_LOOP, 32'(v));
			u_host.wr(rscr_pkg::IDX_REFCTL, 32'(2 * v));
			#1;
			`CHK("out_on", v[0], chan_cfg.out_on)
			`CHK("standby", v[0], chan_cfg.standby)
			`CHK("loop", v[0], chan_cfg.loop_open)
			`CHK("ref100", v[0], ref_out_100m)
		end
	endtask

	// Attenuator banks; low bank clips at its ceiling
	task automatic t_atten();
		u_host.wr(rscr_pkg::IDX_ATTEN, 32'h0FF);
		#1;
		`CHK("hf", 10'h2FF, atten_cfg[17:8])
		u_host.wr(rscr_pkg::IDX_ATTEN, 32'h128);
		#1;
		`CHK("lf_bank", 2'b11, atten_cfg[17:16])
		`CHK("lf", rscr_pkg::LF_ATT_MAX, atten_cfg.lf_code)
	endtask

	// Store and load back to back, then one trigger
	task automatic t_xfer();
		int r0;
		int t0;
		r0 = n_req;
		t0 = n_trig;
		u_host.wr(rscr_pkg::IDX_POINTS, 32'h0123);
		u_host.wr(rscr_pkg::IDX_XFER, 32'h0);
		#1;
		`CHK("to_nvm", 1'b0, xfer_cmd.to_buffer)
		`CHK("points", 16'h0123, xfer_cmd.points)
		u_host.wr(rscr_pkg::IDX_XFER, 32'h1);
		u_host.wr(rscr_pkg::IDX_TRIG, 32'h0);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("to_buf", 1'b1, xfer_cmd.to_buffer)
		`CHK("n_req", r0 + 2, n_req)
		`CHK("n_trig", t0 + 1, n_trig)
	endtask

	// Lock only with a detected reference; status and unmapped reads
	task automatic t_lock();
		logic [31:0] q;
		u_host.wr(rscr_pkg::IDX_REFCTL, 32'h1);
		repeat (8) @(posedge core_clk);
		#1;
		`CHK("nolock", 1'b0, ext_lock_try)
		@(posedge core_clk);
		ext_ref_present <= 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		`CHK("lock", 1'b1, ext_lock_try)
		u_host.xfer(1'b0, rscr_pkg::IDX_STATUS, 32'h0, q);
		`CHK("st_lock", 1'b1, q[1])
		u_host.xfer(1'b0, 8'h01, 32'h0, q);
		`CHK("unmapped", 32'h0, q)
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("ready", 1'b1, hreadyout)
		`CHK("okay", 1'b0, hresp)
		`CHK("trim0", rscr_pkg::RST_TRIM, osc_trim)
		t_freq();
		t_bits();
		t_atten();
		t_xfer();
		t_lock();
		finish_test();
	end
endmodule
`default_nettype wire

// [test/rscr_config_bank_properties.sv]
// Checker: bus timing and write effects of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module rscr_config_bank_properties #(
	parameter int ADDR_W = 8
) (
	input wire logic                 core_clk,
	input wire logic                 srst,
	input wire logic                 hsel,
	input wire logic [ADDR_W-1:0]    haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic [31:0]          hwdata,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire logic                 ext_ref_present,
	input wire rscr_pkg::rscr_chan_t chan_cfg,
	input wire rscr_pkg::rscr_xfer_t xfer_cmd,
	input wire logic                 soft_trigger,
	input wire logic                 relevel_req,
	input wire logic                 ext_lock_try,
	input wire logic                 ref_out_100m
);
	// ----------------------------------------------------------------
	// Address decode of a write taken on this edge
	// ----------------------------------------------------------------
	wire logic       wr_go = hsel && hready && htrans[1] && hwrite;
	wire logic [7:0] ba    = 8'(haddr);
	wire logic [7:0] idx   = {2'b00, ba[7:2]};

	// One clock domain, so one default clocking
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	ready_after_reset_a: assert property (
		!srst |=> hreadyout) else $error("hreadyout low after reset");
	bus_okay_a: assert property (
		hresp == 1'b0) else $error("response not OKAY");
	trig_pulse_a: assert property (
		wr_go && idx == rscr_pkg::IDX_TRIG |-> ##2 soft_trigger ##1 !soft_trigger)
		else $error("trigger pulse wrong");
	xfer_dir_a: assert property (
		wr_go && idx == rscr_pkg::IDX_XFER |-> ##2 xfer_cmd.req &&
		xfer_cmd.to_buffer == $past(hwdata[0])) else $error("transfer wrong");
	level_take_a: assert property (
		wr_go && idx == rscr_pkg::IDX_LEVEL |-> ##2 relevel_req &&
		{chan_cfg.level_neg, chan_cfg.level_mag} == $past(hwdata[15:0]))
		else $error("power level wrong");
	freq_low_a: assert property (
		wr_go && idx == rscr_pkg::IDX_FREQ |->
		##2 chan_cfg.freq_mhz[31:0] == $past(hwdata)) else $error("freq wrong");
	freq_relevel_a: assert property (
		wr_go && idx == rscr_pkg::IDX_FREQ |->
		##2 relevel_req == !chan_cfg.auto_lvl_off) else $error("relevel wrong");
	lock_gate_a: assert property (
		!ext_ref_present [*6] |-> !ext_lock_try) else $error("lock w/o ref");
	ref_select_a: assert property (
		wr_go && idx == rscr_pkg::IDX_REFCTL |->
		##2 ref_out_100m == $past(hwdata[1])) else $error("ref out wrong");
endmodule

bind rscr_config_bank rscr_config_bank_properties #(.ADDR_W(ADDR_W)) u_props (
	.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hreadyout(hreadyout), .hresp(hresp), .ext_ref_present(ext_ref_present),
	.chan_cfg(chan_cfg), .xfer_cmd(xfer_cmd), .soft_trigger(soft_trigger),
	.relevel_req(relevel_req), .ext_lock_try(ext_lock_try),
	.ref_out_100m(ref_out_100m));
`default_nettype wire

// [test/rscr_host_model.sv]
// Host model: AHB-Lite master issuing single word transfers by index
`timescale 1ns/1ps
`default_nettype none
module rscr_host_model (
	input  wire logic        core_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// One transfer; held until hready, released data shows its inverse
	task automatic xfer(input logic wr, input logic [7:0] ix,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {ix[5:0], 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask

	task automatic wr(input logic [7:0] ix, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, ix, d, q);
	endtask

	// Wide value: upper part staged first, low word last
	task automatic wr56(input logic [7:0] ix, input logic [55:0] d);
		wr(rscr_pkg::IDX_UPPER, {8'h00, d[55:32]});
		wr(ix, d[31:0]);
	endtask
endmodule
`default_nettype wire

// [verilog/rscr_config_bank.sv]
// Write-only configuration register bank of the RF source, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

// Contract
// - A transfer write with bit 0 clear stores the list buffer to nonvolatile memory sized by the point count, and with bit 0 set loads it back.
// - Any write to the software trigger register fires one trigger event whatever its payload.
// - The output frequency register holds a 56-bit unsigned millihertz value for channel one.
// - The power level register takes a 15-bit magnitude in hundredths of a dB with the sign in bit 15, set meaning negative.
// - Output enable bit 0 turns the channel one output power off at 0 and on at 1.
// - The phase register carries a 31-bit value in hundredths of a degree and the host writes bit 31 and above as zero.
// - With auto-leveling bit 0 clear power is re-leveled on every frequency change, with it set only on a power level write.
// - Level-loop bit 0 selects closed-loop correction at 0 and open-loop correction at 1.
// - Standby bit 0 set powers down channel one.
// - Reference bit 0 requests external lock, and no lock is attempted while no external reference is detected.
// - Reference bit 1 selects a 10 MHz reference output at 0 and 100 MHz at 1.
// - The trim register takes a 14-bit oscillator adjustment in its low bits, upper bits written as zero.
// - The 8-bit attenuation steps 0.25 dB up to 63.75 dB on the high bank and 1 dB up to 32 dB on the low bank.
// - Attenuator bit 8 picks the low bank when set and the written value overrides the calibrated setting.
// - Memory transfers are sized by the 16-bit list point count register, which overrides any loaded count.
module rscr_config_bank #(
	parameter int FREQ_W  = 56,
	parameter int ADDR_W  = 8
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 hsel,
	input  wire logic [ADDR_W-1:0]    haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 ext_ref_present,
	output rscr_pkg::rscr_chan_t      chan_cfg,
	output rscr_pkg::rscr_atten_t     atten_cfg,
	output rscr_pkg::rscr_xfer_t      xfer_cmd,
	output logic                      soft_trigger,
	output logic                      relevel_req,
	output logic                      ext_lock_try,
	output logic                      ref_out_100m,
	output logic [13:0]               osc_trim
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (FREQ_W != 56) begin : g_chk_freq
		$error("rscr_config_bank: FREQ_W must be 56");
	end
	if (ADDR_W < 8) begin : g_chk_addr
		$error("rscr_config_bank: ADDR_W must be at least 8");
	end

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = ADDR_W'({idx, 2'b00});
	endfunction

	// ----------------------------------------------------------------
	// Address phase capture
	// ----------------------------------------------------------------
	logic                 ap_valid;
	logic                 wr_pend_r;
	logic                 wr_pend_nxt;
	logic [ADDR_W-1:0]    wr_addr_r;
	logic [ADDR_W-1:0]    wr_addr_nxt;

	// Only single word transfers; narrower sizes still land whole
	assign ap_valid    = hsel & hready & htrans[1];
	assign wr_pend_nxt = ap_valid & hwrite;
	assign wr_addr_nxt = ap_valid ? haddr : wr_addr_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Data phase write decode
	// ----------------------------------------------------------------
	logic wr_points;
	logic wr_xfer;
	logic wr_trig;
	logic wr_freq;
	logic wr_level;
	logic wr_enable;
	logic wr_phase;
	logic wr_autolvl;
	logic wr_loop;
	logic wr_standby;
	logic wr_refctl;
	logic wr_trim;
	logic wr_atten;
	logic wr_upper;

	assign wr_points  = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_POINTS));
	assign wr_xfer    = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_XFER));
	assign wr_trig    = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_TRIG));
	assign wr_freq    = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_FREQ));
	assign wr_level   = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_LEVEL));
	assign wr_enable  = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_ENABLE));
	assign wr_phase   = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_PHASE));
	assign wr_autolvl = wr_pend_r
		& (wr_addr_r == reg_addr(rscr_pkg::IDX_AUTOLVL));
	assign wr_loop    = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_LOOP));
	assign wr_standby = wr_pend_r
		& (wr_addr_r == reg_addr(rscr_pkg::IDX_STANDBY));
	assign wr_refctl  = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_REFCTL));
	assign wr_trim    = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_TRIM));
	assign wr_atten   = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_ATTEN));
	assign wr_upper   = wr_pend_r & (wr_addr_r == reg_addr(rscr_pkg::IDX_UPPER));

	// ----------------------------------------------------------------
	// Upper-part staging for the 56-bit frequency register
	// ----------------------------------------------------------------
	logic [rscr_pkg::UPPER_W-1:0] upper_r;

	// Upper part must come first; the low word commits the whole value
	always_ff @(posedge core_clk) begin
		if (srst) begin
			upper_r <= '0;
		end else if (wr_upper) begin
			upper_r <= hwdata[rscr_pkg::UPPER_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Channel configuration registers
	// ----------------------------------------------------------------
	logic [FREQ_W-1:0] freq_nxt;
	assign freq_nxt = {upper_r, hwdata};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			chan_cfg          <= '0;
			chan_cfg.freq_mhz <= rscr_pkg::RST_FREQ;
		end else begin
			if (wr_freq)
				chan_cfg.freq_mhz <= freq_nxt;
			if (wr_level) begin
				chan_cfg.level_mag <= hwdata[rscr_pkg::LVL_MAG_W-1:0];
				chan_cfg.level_neg <= hwdata[rscr_pkg::BIT_LVL_SIGN];
			end
			if (wr_enable)
				chan_cfg.out_on <= hwdata[rscr_pkg::BIT_CTL0];
			if (wr_phase)
				chan_cfg.phase <= hwdata[rscr_pkg::PHASE_W-1:0];
			if (wr_autolvl)
				chan_cfg.auto_lvl_off <= hwdata[rscr_pkg::BIT_CTL0];
			if (wr_loop)
				chan_cfg.loop_open <= hwdata[rscr_pkg::BIT_CTL0];
			if (wr_standby)
				chan_cfg.standby <= hwdata[rscr_pkg::BIT_CTL0];
		end
	end

	// ----------------------------------------------------------------
	// Leveling request
	// ----------------------------------------------------------------
	logic relevel_nxt;

	// Frequency change re-levels only while auto leveling stays on
	assign relevel_nxt = wr_level
		| (wr_freq & ~chan_cfg.auto_lvl_off);

	always_ff @(posedge core_clk) begin
		if (srst)
			relevel_req <= 1'b0;
		else
			relevel_req <= relevel_nxt;
	end

	// ----------------------------------------------------------------
	// Trigger and list store transfer
	// ----------------------------------------------------------------
	logic [rscr_pkg::POINTS_W-1:0] points_r;

	// Point count set here wins over any count from buffer loading
	always_ff @(posedge core_clk) begin
		if (srst)
			points_r <= rscr_pkg::RST_POINTS;
		else if (wr_points)
			points_r <= hwdata[rscr_pkg::POINTS_W-1:0];
	end

	// Payload ignored: any write is one trigger
	always_ff @(posedge core_clk) begin
		if (srst)
			soft_trigger <= 1'b0;
		else
			soft_trigger <= wr_trig;
	end

	// Direction latched with the request; length is the point count
	always_ff @(posedge core_clk) begin
		if (srst) begin
			xfer_cmd <= '0;
		end else begin
			xfer_cmd.req <= wr_xfer;
			if (wr_xfer) begin
				xfer_cmd.to_buffer <= hwdata[rscr_pkg::BIT_CTL0];
				xfer_cmd.points    <= points_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reference control and oscillator trim
	// ----------------------------------------------------------------
	logic       ext_lock_req_r;
	logic [2:0] ref_sync_r;
	logic       ref_seen_r;
	logic       ref_seen_nxt;

	// Detect pin is asynchronous; stage 1 feeds only stage 2
	always_ff @(posedge core_clk) begin
		if (srst)
			ref_sync_r <= 3'h0;
		else
			ref_sync_r <= {ref_sync_r[1:0], ext_ref_present};
	end

	// Presence changes only once the last two stages agree
	assign ref_seen_nxt = (ref_sync_r[2] == ref_sync_r[1])
		? ref_sync_r[2] : ref_seen_r;

	always_ff @(posedge core_clk) begin
		if (srst)
			ref_seen_r <= 1'b0;
		else
			ref_seen_r <= ref_seen_nxt;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ext_lock_req_r <= 1'b0;
			ref_out_100m   <= 1'b0;
		end else if (wr_refctl) begin
			ext_lock_req_r <= hwdata[rscr_pkg::BIT_CTL0];
			ref_out_100m   <= hwdata[rscr_pkg::BIT_REFOUT];
		end
	end

	// No lock attempt without a detected reference
	always_ff @(posedge core_clk) begin
		if (srst)
			ext_lock_try <= 1'b0;
		else
			ext_lock_try <= ext_lock_req_r & ref_seen_r;
	end

	// Upper bits dropped even if the host sets them
	always_ff @(posedge core_clk) begin
		if (srst)
			osc_trim <= rscr_pkg::RST_TRIM;
		else if (wr_trim)
			osc_trim <= hwdata[rscr_pkg::TRIM_W-1:0];
	end

	// ----------------------------------------------------------------
	// Manual attenuator override
	// ----------------------------------------------------------------
	logic [rscr_pkg::ATT_W-1:0] att_val;
	logic [rscr_pkg::ATT_W-1:0] lf_clamped;

	assign att_val = hwdata[rscr_pkg::ATT_W-1:0];
	// Low bank tops out at 32 dB; larger codes saturate
	assign lf_clamped = (att_val > rscr_pkg::LF_ATT_MAX)
		? rscr_pkg::LF_ATT_MAX : att_val;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			atten_cfg <= '0;
		end else if (wr_atten) begin
			atten_cfg.override <= 1'b1;
			atten_cfg.lf_bank  <= hwdata[rscr_pkg::BIT_ATT_BANK];
			if (hwdata[rscr_pkg::BIT_ATT_BANK])
				atten_cfg.lf_code <= lf_clamped;
			else
				atten_cfg.hf_code <= att_val;
		end
	end

	// ----------------------------------------------------------------
	// Read path: status word only, registers are write-only
	// ----------------------------------------------------------------
	logic        rd_status;
	logic [31:0] status_word;
	logic [31:0] rdata_nxt;

	assign rd_status = ap_valid & ~hwrite
		& (haddr == reg_addr(rscr_pkg::IDX_STATUS));
	assign status_word = {points_r, 8'h00,
		atten_cfg.override, chan_cfg.standby, chan_cfg.out_on,
		ref_out_100m, ext_lock_req_r, ref_seen_r, ext_lock_try,
		xfer_cmd.to_buffer};
	// Other addresses, mapped or not, read as zero
	assign rdata_nxt = rd_status ? status_word : 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= rdata_nxt;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule

`default_nettype wire
